/* rtl/rsc_pkg.sv */
`default_nettype none
package rsc_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [15:0] REG5_SLEEP_IDX = 16'h4076;
  localparam logic [15:0] REG6_CTRL_IDX = 16'h4077;
  localparam logic [15:0] IRQ_STATUS_IDX = 16'h40F0;
  localparam logic [15:0] IRQ_MASK_IDX = 16'h40F1;
  // Sleep control fields.
  localparam int SLP_SLOT_LSB = 13;
  localparam int SLP_MODE_BIT = 8;
  localparam int SLP_VCODE_LSB = 0;
  // Control word fields.
  localparam int UV_ACT_LSB = 14;
  localparam int HWC_SRC_LSB = 11;
  localparam int HWC_VSEL_BIT = 10;
  localparam int HWC_MODE_LSB = 8;
  localparam int FLOAT_BIT = 7;
  localparam int SWITCH_BIT = 6;
  localparam int LP_VAR_BIT = 0;
  localparam int UV_STATUS_BIT = 0;
  // Reset values and writable-bit masks.
  localparam logic [15:0] REG5_SLEEP_RESET = 16'h0100;
  localparam logic [15:0] REG6_CTRL_RESET = 16'h0200;
  localparam logic [15:0] REG5_SLEEP_WMASK = 16'hE11F;
  localparam logic [15:0] REG6_CTRL_WMASK = 16'hDFC1;
  localparam logic [15:0] IRQ_WMASK = 16'h0001;
  localparam logic [15:0] IRQ_MASK_RESET = 16'h0000;
  // Slot codes.
  localparam logic [2:0] SLOT_TR5 = 3'h0;
  localparam logic [2:0] SLOT_TR3 = 3'h6;
  localparam logic [2:0] SLOT_TR1 = 3'h7;
  localparam logic [2:0] SLOT_DIS_FIRST = 3'h1;
  localparam logic [2:0] SLOT_DIS_LAST = 3'h5;
  localparam logic [2:0] SLOT_DIS_BASE = 3'h6;
  localparam logic [2:0] ON_SLOT_HWE1 = 3'h6;
  localparam logic [2:0] ON_SLOT_HWE2 = 3'h7;
  // Undervoltage actions, hardware sources and hardware modes.
  localparam logic [1:0] UV_IGNORE = 2'h0;
  localparam logic [1:0] UV_SHUT_REG = 2'h1;
  localparam logic [1:0] UV_SHUT_SYS = 2'h2;
  localparam logic [1:0] HWC_SRC_1 = 2'h1;
  localparam logic [1:0] HWC_SRC_2 = 2'h2;
  localparam logic [1:0] HWC_SRC_ANY = 2'h3;
  localparam logic [1:0] HWC_MODE_OFF = 2'h1;
  localparam logic [1:0] HWC_MODE_ON = 2'h3;
  // Voltage code map in millivolts.
  localparam logic [4:0] VCODE_KNEE = 5'h0F;
  localparam logic [11:0] MV_LOW_BASE = 12'h0384;
  localparam logic [11:0] MV_LOW_STEP = 12'h0032;
  localparam logic [11:0] MV_HIGH_BASE = 12'h06A4;
  localparam logic [11:0] MV_HIGH_STEP = 12'h0064;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* rtl/rsc_regs.sv */
// Behaviour
// - Codes 000/110/111 transition in slots 5/3/1.
// - Codes 001-101 disable in slots 5 down to 1.
// - Hardware-enabled regulator: those codes enter sleep instead.
// - Sleep mode bit 8, resets 1, 1=low power.
// - Voltage code 50mV then 100mV steps from 0Fh.
// - Sleep voltage code bits 4:0, resets zero.
// - Undervoltage action: ignore, regulator off, system reset.
// - Every undervoltage event sets the status bit; it raises the interrupt only when unmasked.
// - Hardware source: none, input 1, 2, either.
// - Bit 10 picks ON or sleep voltage code.
// - Hardware mode: low power, off, or ON mode.
// - Bit 7 clear discharges a disabled output.
// - Bit 0 picks the low power variant.
// - ON slot 110/111 assigns hardware enable input.
`timescale 1ns/10ps
`default_nettype none
module rsc_regs #(
  parameter int ADDR_W = 18
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic [2:0] i_reg5_on_slot,
  input wire logic i_sleep_step,
  input wire logic [2:0] i_timeslot,
  input wire logic i_hw_enable1,
  input wire logic i_hw_enable2,
  input wire logic [4:0] i_reg6_on_voltage_code,
  input wire logic [4:0] i_reg6_sleep_voltage_code,
  input wire logic i_reg6_on_mode,
  input wire logic i_reg6_undervoltage,
  output logic o_reg5_sleep_apply,
  output logic o_reg5_disable,
  output logic o_reg5_sleep_enter,
  output logic o_reg5_sleep_mode,
  output logic [4:0] o_reg5_sleep_voltage_code,
  output logic [11:0] o_reg5_sleep_millivolts,
  output logic o_reg6_hw_active,
  output logic [4:0] o_reg6_voltage_code,
  output logic o_reg6_hw_off,
  output logic o_reg6_low_power,
  output logic o_reg6_discharge,
  output logic o_reg6_switch_operation,
  output logic o_reg6_low_power_variant,
  output logic o_reg6_uv_shutdown,
  output logic o_system_reset,
  output logic o_irq
);
  logic [15:0] reg5_sleep_reg, reg5_sleep_next;
  logic [15:0] reg6_ctrl_reg, reg6_ctrl_next;
  logic [15:0] status_reg, status_next;
  logic [15:0] mask_reg, mask_next;
  logic [ADDR_W-1:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic aw_have_reg, w_have_reg;

  function automatic logic [11:0] rsc_code_to_mv(input logic [4:0] code);
    logic [11:0] c;
    c = {7'h00, code};
    if (code < rsc_pkg::VCODE_KNEE) begin
      rsc_code_to_mv = rsc_pkg::MV_LOW_BASE + 12'(c * rsc_pkg::MV_LOW_STEP);
    end else begin
      rsc_code_to_mv = rsc_pkg::MV_HIGH_BASE
        + 12'((c - {7'h00, rsc_pkg::VCODE_KNEE}) * rsc_pkg::MV_HIGH_STEP);
    end
  endfunction

  // Field views.
  wire [2:0] slp_slot = reg5_sleep_reg[rsc_pkg::SLP_SLOT_LSB +: 3];
  wire [4:0] slp_vcode = reg5_sleep_reg[rsc_pkg::SLP_VCODE_LSB +: 5];
  wire [1:0] uv_act = reg6_ctrl_reg[rsc_pkg::UV_ACT_LSB +: 2];
  wire [1:0] hwc_src = reg6_ctrl_reg[rsc_pkg::HWC_SRC_LSB +: 2];
  wire [1:0] hwc_mode = reg6_ctrl_reg[rsc_pkg::HWC_MODE_LSB +: 2];
  wire hwc_vsel = reg6_ctrl_reg[rsc_pkg::HWC_VSEL_BIT];

  // Sleep sequencing decode.
  wire hw_assigned = (i_reg5_on_slot == rsc_pkg::ON_SLOT_HWE1)
    || (i_reg5_on_slot == rsc_pkg::ON_SLOT_HWE2);
  wire dis_code = (slp_slot >= rsc_pkg::SLOT_DIS_FIRST)
    && (slp_slot <= rsc_pkg::SLOT_DIS_LAST);
  wire [2:0] dis_slot = rsc_pkg::SLOT_DIS_BASE - slp_slot;
  wire [2:0] tr_slot = (slp_slot == rsc_pkg::SLOT_TR5) ? 3'h5
    : (slp_slot == rsc_pkg::SLOT_TR3) ? 3'h3 : 3'h1;
  wire hit_tr = i_sleep_step && !dis_code && (i_timeslot == tr_slot);
  wire hit_dis = i_sleep_step && dis_code && (i_timeslot == dis_slot);
  wire apply_next = hit_tr;
  wire disable_next = hit_dis && !hw_assigned;
  wire enter_next = hit_dis && hw_assigned;

  // Hardware control of the sixth regulator.
  wire hw_active_next = (hwc_src == rsc_pkg::HWC_SRC_1) ? i_hw_enable1
    : (hwc_src == rsc_pkg::HWC_SRC_2) ? i_hw_enable2
    : (hwc_src == rsc_pkg::HWC_SRC_ANY) ? (i_hw_enable1 || i_hw_enable2)
    : 1'b0;
  wire [4:0] vcode_next = (hw_active_next && hwc_vsel)
    ? i_reg6_sleep_voltage_code : i_reg6_on_voltage_code;
  wire hw_off_next = hw_active_next && (hwc_mode == rsc_pkg::HWC_MODE_OFF);
  wire lp_next = hw_active_next ? ((hwc_mode == rsc_pkg::HWC_MODE_ON) ? i_reg6_on_mode
    : (hwc_mode != rsc_pkg::HWC_MODE_OFF)) : i_reg6_on_mode;

  // Undervoltage handling; the reserved code takes no action.
  wire uv_shut_next = i_reg6_undervoltage && (uv_act == rsc_pkg::UV_SHUT_REG);
  wire sys_rst_next = i_reg6_undervoltage && (uv_act == rsc_pkg::UV_SHUT_SYS);

  // Write channel: address and data are latched in either order.
  wire aw_hs = i_awvalid && o_awready;
  wire w_hs = i_wvalid && o_wready;
  wire wr_fire = aw_have_reg && w_have_reg && !o_bvalid;
  wire [15:0] wr_idx = waddr_reg[17:2];
  wire wr_hi_zero = (ADDR_W <= 18) || (waddr_reg >> 18) == '0;
  wire wr_sel5 = wr_fire && wr_hi_zero && (wr_idx == rsc_pkg::REG5_SLEEP_IDX);
  wire wr_sel6 = wr_fire && wr_hi_zero && (wr_idx == rsc_pkg::REG6_CTRL_IDX);
  wire wr_selst = wr_fire && wr_hi_zero && (wr_idx == rsc_pkg::IRQ_STATUS_IDX);
  wire wr_selmk = wr_fire && wr_hi_zero && (wr_idx == rsc_pkg::IRQ_MASK_IDX);
  wire wr_hit = wr_sel5 || wr_sel6 || wr_selst || wr_selmk;
  wire [15:0] be = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  wire [15:0] wd = wdata_reg[15:0];

  function automatic logic [15:0] rsc_merge(input logic [15:0] old, input logic [15:0] d,
                                            input logic [15:0] en, input logic [15:0] wm);
    rsc_merge = (old & ~(en & wm)) | (d & en & wm);
  endfunction

  assign reg5_sleep_next = wr_sel5
    ? rsc_merge(reg5_sleep_reg, wd, be, rsc_pkg::REG5_SLEEP_WMASK) : reg5_sleep_reg;
  assign reg6_ctrl_next = wr_sel6
    ? rsc_merge(reg6_ctrl_reg, wd, be, rsc_pkg::REG6_CTRL_WMASK) : reg6_ctrl_reg;
  assign mask_next = wr_selmk
    ? rsc_merge(mask_reg, wd, be, rsc_pkg::IRQ_WMASK) : mask_reg;
  // A new event wins over a write-one-to-clear in the same cycle.
  wire [15:0] st_clr = wr_selst ? (wd & be & rsc_pkg::IRQ_WMASK) : 16'h0000;
  wire [15:0] st_set = 16'(i_reg6_undervoltage) << rsc_pkg::UV_STATUS_BIT;
  assign status_next = (status_reg & ~st_clr) | st_set;
  wire irq_next = |(status_next & ~mask_next);

  // Read decode.
  wire ar_hs = i_arvalid && o_arready;
  wire [15:0] rd_idx = i_araddr[17:2];
  wire rd_hi_zero = (ADDR_W <= 18) || (i_araddr >> 18) == '0;
  wire rd_sel5 = rd_hi_zero && (rd_idx == rsc_pkg::REG5_SLEEP_IDX);
  wire rd_sel6 = rd_hi_zero && (rd_idx == rsc_pkg::REG6_CTRL_IDX);
  wire rd_selst = rd_hi_zero && (rd_idx == rsc_pkg::IRQ_STATUS_IDX);
  wire rd_selmk = rd_hi_zero && (rd_idx == rsc_pkg::IRQ_MASK_IDX);
  wire rd_hit = rd_sel5 || rd_sel6 || rd_selst || rd_selmk;
  wire [15:0] rd_val = rd_sel5 ? reg5_sleep_reg : rd_sel6 ? reg6_ctrl_reg
    : rd_selst ? status_reg : rd_selmk ? mask_reg : 16'h0000;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      reg5_sleep_reg <= rsc_pkg::REG5_SLEEP_RESET;
      reg6_ctrl_reg <= rsc_pkg::REG6_CTRL_RESET;
      status_reg <= 16'h0000;
      mask_reg <= rsc_pkg::IRQ_MASK_RESET;
      o_irq <= 1'b0;
    end else begin
      reg5_sleep_reg <= reg5_sleep_next;
      reg6_ctrl_reg <= reg6_ctrl_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      o_irq <= irq_next;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      waddr_reg <= '0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      o_bvalid <= 1'b0;
      o_bresp <= rsc_pkg::RESP_OKAY;
    end else begin
      if (aw_hs) begin
        o_awready <= 1'b0;
        aw_have_reg <= 1'b1;
        waddr_reg <= i_awaddr;
      end
      if (w_hs) begin
        o_wready <= 1'b0;
        w_have_reg <= 1'b1;
        wdata_reg <= i_wdata;
        wstrb_reg <= i_wstrb;
      end
      if (wr_fire) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= wr_hit ? rsc_pkg::RESP_OKAY : rsc_pkg::RESP_SLVERR;
      end
      if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= rsc_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rdata <= {16'h0000, rd_val};
      o_rresp <= rd_hit ? rsc_pkg::RESP_OKAY : rsc_pkg::RESP_SLVERR;
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  // Regulator-facing outputs are registered so they never glitch on a write.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg5_sleep_apply <= 1'b0;
      o_reg5_disable <= 1'b0;
      o_reg5_sleep_enter <= 1'b0;
      o_reg5_sleep_mode <= 1'b1;
      o_reg5_sleep_voltage_code <= 5'h00;
      o_reg5_sleep_millivolts <= rsc_pkg::MV_LOW_BASE;
      o_reg6_hw_active <= 1'b0;
      o_reg6_voltage_code <= 5'h00;
      o_reg6_hw_off <= 1'b0;
      o_reg6_low_power <= 1'b0;
      o_reg6_discharge <= 1'b1;
      o_reg6_switch_operation <= 1'b0;
      o_reg6_low_power_variant <= 1'b0;
      o_reg6_uv_shutdown <= 1'b0;
      o_system_reset <= 1'b0;
    end else begin
      o_reg5_sleep_apply <= apply_next;
      o_reg5_disable <= disable_next;
      o_reg5_sleep_enter <= enter_next;
      o_reg5_sleep_mode <= reg5_sleep_reg[rsc_pkg::SLP_MODE_BIT];
      o_reg5_sleep_voltage_code <= slp_vcode;
      o_reg5_sleep_millivolts <= rsc_code_to_mv(slp_vcode);
      o_reg6_hw_active <= hw_active_next;
      o_reg6_voltage_code <= vcode_next;
      o_reg6_hw_off <= hw_off_next;
      o_reg6_low_power <= lp_next;
      o_reg6_discharge <= !reg6_ctrl_reg[rsc_pkg::FLOAT_BIT];
      o_reg6_switch_operation <= reg6_ctrl_reg[rsc_pkg::SWITCH_BIT];
      o_reg6_low_power_variant <= reg6_ctrl_reg[rsc_pkg::LP_VAR_BIT];
      o_reg6_uv_shutdown <= uv_shut_next;
      o_system_reset <= sys_rst_next;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  slot_transition_a: assert property (
    i_sleep_step && slp_slot == rsc_pkg::SLOT_TR3 && i_timeslot == 3'h3
    |=> o_reg5_sleep_apply && !o_reg5_disable)
    else $error("Sleep transition missed its timeslot.");
  slot_disable_a: assert property (
    i_sleep_step && slp_slot == 3'h2 && !hw_assigned && i_timeslot == 3'h4
    |=> o_reg5_disable ##1 !o_reg5_disable || $past(i_sleep_step))
    else $error("Disable did not fire in timeslot four.");
  slot_enter_a: assert property (
    o_reg5_sleep_enter |-> $past(hw_assigned) && !o_reg5_disable && !o_reg5_sleep_apply)
    else $error("Sleep entry without hardware enable assignment.");
  sleep_mode_a: assert property (
    o_reg5_sleep_mode == $past(reg5_sleep_reg[8]))
    else $error("Sleep mode output lags its field.");
  voltage_map_a: assert property (
    $past(slp_vcode) == rsc_pkg::VCODE_KNEE |-> o_reg5_sleep_millivolts == 12'h06A4)
    else $error("Code 0Fh does not map to 1.70 V.");
  voltage_range_a: assert property (
    o_reg5_sleep_millivolts >= 12'h0384 && o_reg5_sleep_millivolts <= 12'h0CE4)
    else $error("Sleep voltage outside 0.90 V to 3.30 V.");
  uv_action_a: assert property (
    i_reg6_undervoltage && uv_act == rsc_pkg::UV_SHUT_SYS
    |=> o_system_reset && !o_reg6_uv_shutdown ##1 !o_system_reset || $past(i_reg6_undervoltage))
    else $error("System reset not raised on undervoltage.");
  uv_irq_a: assert property (
    i_reg6_undervoltage && !mask_reg[0] && !wr_selmk |=> status_reg[0] && o_irq)
    else $error("Undervoltage did not raise the interrupt.");
  hw_source_a: assert property (
    hwc_src == 2'h0 |=> !o_reg6_hw_active)
    else $error("Hardware control active while disabled.");
  hw_voltage_a: assert property (
    hw_active_next && hwc_vsel |=> o_reg6_voltage_code == $past(i_reg6_sleep_voltage_code))
    else $error("Hardware voltage choice ignored.");
  hw_off_a: assert property (
    o_reg6_hw_off |-> !o_reg6_low_power && o_reg6_hw_active)
    else $error("Off mode mixed with low power.");
  reserved_zero_a: assert property (
    o_rvalid |-> o_rdata[31:16] == 16'h0000 && !reg5_sleep_reg[12] && !reg6_ctrl_reg[13])
    else $error("Reserved bits not zero.");
  uv_shutdown_a: assert property (
    i_reg6_undervoltage && uv_act == rsc_pkg::UV_SHUT_REG
    |=> o_reg6_uv_shutdown && !o_system_reset)
    else $error("Regulator shutdown not raised on undervoltage.");
  slot_exclusive_a: assert property (
    !(o_reg5_disable && (o_reg5_sleep_apply || o_reg5_sleep_enter)))
    else $error("Sleep pulses overlap.");
  hw_mode_on_a: assert property (
    hw_active_next && hwc_mode == rsc_pkg::HWC_MODE_ON
    |=> o_reg6_low_power == $past(i_reg6_on_mode))
    else $error("Hardware mode 11 ignores the ON mode bit.");
  float_write_a: assert property (
    wr_sel6 && be[rsc_pkg::FLOAT_BIT]
    |-> ##2 o_reg6_discharge == !$past(wd[rsc_pkg::FLOAT_BIT], 2))
    else $error("Discharge output ignores the float bit.");
  switch_write_a: assert property (
    wr_sel6 && be[rsc_pkg::SWITCH_BIT]
    |-> ##2 o_reg6_switch_operation == $past(wd[rsc_pkg::SWITCH_BIT], 2))
    else $error("Switch output ignores its bit.");
  lp_variant_a: assert property (
    wr_sel6 && be[rsc_pkg::LP_VAR_BIT]
    |-> ##2 o_reg6_low_power_variant == $past(wd[rsc_pkg::LP_VAR_BIT], 2))
    else $error("Low power variant ignores its bit.");
  write_answer_a: assert property (
    aw_hs && w_hs |-> ##2 o_bvalid)
    else $error("Write response late.");
  read_answer_a: assert property (
    ar_hs && !rd_hit
    |=> o_rvalid && o_rresp == rsc_pkg::RESP_SLVERR && o_rdata == 32'h0000_0000)
    else $error("Unmapped read not refused with zero data.");

  write_seen_c: cover property (wr_sel6 ##[1:4] o_bvalid && i_bready);
  irq_clear_c: cover property (o_irq ##[1:20] !o_irq);
  enter_seen_c: cover property (o_reg5_sleep_enter);
  reset_seen_c: cover property (o_system_reset);
  disable_seen_c: cover property (o_reg5_disable);
endmodule // rsc_regs
`default_nettype wire

/* tb/test_regulator_sleep_and_control_regs.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin n_mismatch++; \
  $display("BAD %s exp %0h got %0h", nm, ex, gt); end end
module test_regulator_sleep_and_control_regs;
  logic i_clock = 1'h0;
  logic i_rst_n = 1'h0;
  logic [17:0] awaddr = 18'h0_0000, araddr = 18'h0_0000;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic [2:0] on_slot = 3'h0, tslot = 3'h0;
  logic step = 1'h0, en1 = 1'h0, en2 = 1'h0, on_mode = 1'h0, uv = 1'h0;
  logic [4:0] onv = 5'h00, slv = 5'h00;
  logic awready, wready, bvalid, arready, rvalid, apply, dis, enter, smode, hwact, hwoff, lp;
  logic dchg, swop, lpv, uvsd, sysrst, irq;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd, d;
  logic [4:0] svc, vcode;
  logic [11:0] smv;
  int n_mismatch = 0, n_checks = 0, cycles = 0, seed = 77;
  int c, h, t, a, s, m, ha, inr, ap;

  rsc_regs dut (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
    .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_reg5_on_slot(on_slot),
    .i_sleep_step(step), .i_timeslot(tslot), .i_hw_enable1(en1), .i_hw_enable2(en2),
    .i_reg6_on_voltage_code(onv), .i_reg6_sleep_voltage_code(slv), .i_reg6_on_mode(on_mode),
    .i_reg6_undervoltage(uv), .o_reg5_sleep_apply(apply), .o_reg5_disable(dis),
    .o_reg5_sleep_enter(enter), .o_reg5_sleep_mode(smode), .o_reg5_sleep_voltage_code(svc),
    .o_reg5_sleep_millivolts(smv), .o_reg6_hw_active(hwact), .o_reg6_voltage_code(vcode),
    .o_reg6_hw_off(hwoff), .o_reg6_low_power(lp), .o_reg6_discharge(dchg),
    .o_reg6_switch_operation(swop), .o_reg6_low_power_variant(lpv),
    .o_reg6_uv_shutdown(uvsd), .o_system_reset(sysrst), .o_irq(irq)
  );

  always #50 i_clock = ~i_clock;

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // The ceiling is about twenty times the expected run so that slow answers do not trip it.
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // Address and data are released channel by channel as each is taken.
  task automatic axi_write(input logic [15:0] idx, input logic [31:0] dv, output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    @(posedge i_clock);
    awaddr <= {idx, 2'h0};
    awvalid <= 1'h1;
    wdata <= dv;
    wstrb <= 4'h3;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(aw_ok && w_ok)) begin
      @(posedge i_clock);
      if (!aw_ok && awready === 1'h1) begin aw_ok = 1'h1; awvalid <= 1'h0; end
      if (!w_ok && wready === 1'h1) begin w_ok = 1'h1; wvalid <= 1'h0; end
    end
    while (bvalid !== 1'h1) @(posedge i_clock);
    r = bresp;
    bready <= 1'h0;
  endtask

  task automatic axi_read(input logic [15:0] idx, output logic [31:0] dv, output logic [1:0] r);
    @(posedge i_clock);
    araddr <= {idx, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge i_clock); while (arready !== 1'h1);
    arvalid <= 1'h0;
    while (rvalid !== 1'h1) @(posedge i_clock);
    dv = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask

  // Selector 0 pulses the sleep step, any other value the undervoltage event.
  task automatic pulse(input int which);
    @(posedge i_clock);
    if (which == 0) begin
      step <= 1'h1;
    end else begin
      uv <= 1'h1;
    end
    @(posedge i_clock);
    step <= 1'h0;
    uv <= 1'h0;
    @(negedge i_clock);
  endtask

  task automatic check_status(input logic [31:0] ex, input logic ex_irq);
    axi_read(rsc_pkg::IRQ_STATUS_IDX, rd, resp);
    `CHK("status", ex, rd)
    `CHK("irq", ex_irq, irq)
  endtask

  initial begin
    repeat (10) @(posedge i_clock);
    i_rst_n <= 1'h1;
    @(negedge i_clock);
    `CHK("rst mode", 1'h1, smode)
    `CHK("rst mv", 12'h384, smv)
    `CHK("rst dchg", 1'h1, dchg)
    axi_read(rsc_pkg::REG5_SLEEP_IDX, rd, resp);
    `CHK("rst reg5", 32'h0000_0100, rd)
    axi_read(rsc_pkg::REG6_CTRL_IDX, rd, resp);
    `CHK("rst reg6", 32'h0000_0200, rd)
    axi_write(16'h4000, 32'hFFFF_FFFF, resp);
    `CHK("unmapped wr", rsc_pkg::RESP_SLVERR, resp)
    axi_read(16'h4000, rd, resp);
    `CHK("unmapped rd", 32'h0000_0000, rd)
    `CHK("unmapped rresp", rsc_pkg::RESP_SLVERR, resp)
    for (c = 0; c < 32; c++) begin
      d = $random(seed);
      d[4:0] = c[4:0];
      axi_write(rsc_pkg::REG5_SLEEP_IDX, d, resp);
      `CHK("wr resp", rsc_pkg::RESP_OKAY, resp)
      axi_read(rsc_pkg::REG5_SLEEP_IDX, rd, resp);
      `CHK("rd resp", rsc_pkg::RESP_OKAY, resp)
      `CHK("reg5 rb", {16'h0000, d[15:0] & rsc_pkg::REG5_SLEEP_WMASK}, rd)
      `CHK("svc", d[4:0], svc)
      `CHK("smode", d[8], smode)
      `CHK("mv", 12'(c < 15 ? 900 + 50 * c : 1700 + 100 * (c - 15)), smv)
    end
    for (c = 0; c < 8; c++) begin
      for (h = 0; h < 2; h++) begin
        @(posedge i_clock);
        on_slot <= (h == 0) ? 3'h0 : (c[0] ? rsc_pkg::ON_SLOT_HWE2 : rsc_pkg::ON_SLOT_HWE1);
        axi_write(rsc_pkg::REG5_SLEEP_IDX, c << 13, resp);
        for (t = 1; t <= 5; t++) begin
          @(posedge i_clock);
          tslot <= t[2:0];
          pulse(0);
          inr = (c >= 1 && c <= 5 && t == 6 - c);
          ap = (c == 0 && t == 5) || (c == 6 && t == 3) || (c == 7 && t == 1);
          `CHK("apply", 1'(ap), apply)
          `CHK("disable", 1'(inr && h == 0), dis)
          `CHK("enter", 1'(inr && h == 1), enter)
        end
      end
    end
    for (c = 0; c < 24; c++) begin
      d = $random(seed);
      if (d[15:14] == 2'h3) d[15] = 1'h0;
      axi_write(rsc_pkg::REG6_CTRL_IDX, d, resp);
      @(posedge i_clock);
      {en1, en2, on_mode, onv, slv} <= 13'($random(seed));
      repeat (3) @(posedge i_clock);
      @(negedge i_clock);
      s = d[12:11];
      m = d[9:8];
      ha = (s == 1 && en1) || (s == 2 && en2) || (s == 3 && (en1 || en2));
      `CHK("hw act", 1'(ha), hwact)
      `CHK("vcode", (ha && d[10]) ? slv : onv, vcode)
      `CHK("hw off", 1'(ha && m == 1), hwoff)
      if (!(ha && m == 1)) `CHK("low pwr", ha ? (m == 3 ? on_mode : 1'h1) : on_mode, lp)
      `CHK("dchg", ~d[7], dchg)
      `CHK("switch", d[6], swop)
      `CHK("lp var", d[0], lpv)
      axi_read(rsc_pkg::REG6_CTRL_IDX, rd, resp);
      `CHK("reg6 rb", {16'h0000, d[15:0] & rsc_pkg::REG6_CTRL_WMASK}, rd)
    end
    for (a = 0; a < 4; a++) begin
      axi_write(rsc_pkg::REG6_CTRL_IDX, a << 14, resp);
      pulse(1);
      `CHK("uv shut", 1'(a == 1), uvsd)
      `CHK("sys rst", 1'(a == 2), sysrst)
      check_status(32'h0000_0001, 1'h1);
      axi_write(rsc_pkg::IRQ_STATUS_IDX, 32'h0000_0001, resp);
      check_status(32'h0000_0000, 1'h0);
    end
    // A masked event still latches, so unmasking must raise the line.
    axi_write(rsc_pkg::IRQ_MASK_IDX, 32'h0000_0001, resp);
    pulse(1);
    check_status(32'h0000_0001, 1'h0);
    axi_write(rsc_pkg::IRQ_MASK_IDX, 32'h0000_0000, resp);
    check_status(32'h0000_0001, 1'h1);
    axi_write(rsc_pkg::IRQ_STATUS_IDX, 32'h0000_0001, resp);
    check_status(32'h0000_0000, 1'h0);
    report_and_stop();
  end
endmodule // test_regulator_sleep_and_control_regs
`default_nettype wire
